// ---- design/snrwe_sync.sv ----
//Operation
//- Opcode 06H sets the write enable latch
//- Reset command clears the write enable latch
//- Opcode 04H clears the write enable latch
//- Finished program or erase clears the latch
//- 13H with 24-bit address loads cache, busy
//- Get features 0FH accepted while page loads
//- Chip select high ends any cache read
//- Quad reads need quad enable bit set
//- With ECC, 64 code bytes follow spare
//- BBH: 16 address bits, 4 dummies, x2
//- Column advances after each byte until wrap
//- EBH: 16 address bits, 4 dummies, x4
//- EEH: nibble per edge, byte per clock
//- DTR column rolls over to zero at end
//- 9FH outputs maker code then part code
//- ID page: 16 bytes, complement, 16 copies; code repeats the pair over the whole cache, 68 times
//- At least three parameter page copies stored
//- Feature value streams, refreshed, until deselect
//- 03H/0BH/3BH/6BH: 16 address clocks, dummy byte
//- Quad mode uses all four data lines
package snrwe_pkg;
  localparam logic [7:0]  OP_LATCH_SET   = 8'h06;
  localparam logic [7:0]  OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0]  OP_RESET       = 8'hff;
  localparam logic [7:0]  OP_PAGE_READ   = 8'h13;
  localparam logic [7:0]  OP_GET_FEAT    = 8'h0f;
  localparam logic [7:0]  OP_READ_ID     = 8'h9f;
  localparam logic [7:0]  OP_RD_CACHE    = 8'h03;
  localparam logic [7:0]  OP_RD_FAST     = 8'h0b;
  localparam logic [7:0]  OP_RD_X2       = 8'h3b;
  localparam logic [7:0]  OP_RD_X4       = 8'h6b;
  localparam logic [7:0]  OP_RD_DIO      = 8'hbb;
  localparam logic [7:0]  OP_RD_QIO      = 8'heb;
  localparam logic [7:0]  OP_RD_DTR      = 8'hee;
  localparam logic [7:0]  FEAT_CONFIG    = 8'hb0;
  localparam logic [7:0]  FEAT_STATUS    = 8'hc0;
  localparam int          QUAD_EN_BIT    = 0;
  localparam int          ECC_BIT        = 4;
  localparam int          OTP_BIT        = 6;
  localparam int          BUSY_BIT       = 0;
  localparam int          LATCH_BIT      = 1;
  localparam logic [11:0] SPARE_END      = 12'h840;
  localparam logic [11:0] ECC_END        = 12'h880;
  localparam int          CACHE_DEPTH    = 2176;
  localparam logic [23:0] IDENT_PAGE     = 24'h000006;
  localparam logic [23:0] PARAM_PAGE     = 24'h000004;
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          BUSY_NS        = 25000;
  localparam int          BUSY_CYC       = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic [5:0] addr_clks(input logic [7:0] op);
    case (op)
      OP_PAGE_READ:                                    addr_clks = 6'h18;
      OP_GET_FEAT, OP_READ_ID, OP_RD_DIO:              addr_clks = 6'h08;
      OP_RD_CACHE, OP_RD_FAST, OP_RD_X2, OP_RD_X4:     addr_clks = 6'h10;
      OP_RD_QIO, OP_RD_DTR:                            addr_clks = 6'h04;
      default:                                         addr_clks = 6'h00;
    endcase
  endfunction : addr_clks

  function automatic logic [5:0] dummy_clks(input logic [7:0] op);
    case (op)
      OP_RD_CACHE, OP_RD_FAST, OP_RD_X2, OP_RD_X4, OP_RD_DTR: dummy_clks = 6'h08;
      OP_RD_DIO, OP_RD_QIO:                                   dummy_clks = 6'h04;
      default:                                                dummy_clks = 6'h00;
    endcase
  endfunction : dummy_clks

  function automatic logic [2:0] out_lines(input logic [7:0] op);
    case (op)
      OP_GET_FEAT, OP_READ_ID, OP_RD_CACHE, OP_RD_FAST: out_lines = 3'h1;
      OP_RD_X2, OP_RD_DIO:                              out_lines = 3'h2;
      OP_RD_X4, OP_RD_QIO, OP_RD_DTR:                   out_lines = 3'h4;
      default:                                          out_lines = 3'h0;
    endcase
  endfunction : out_lines

  function automatic logic is_quad(input logic [7:0] op);
    is_quad = (op == OP_RD_X4) || (op == OP_RD_QIO) || (op == OP_RD_DTR);
  endfunction : is_quad

  // Parameter page layout, repeated every 256 bytes of the cache
  function automatic logic [7:0] param_byte(input logic [7:0] idx);
    case (idx)
      8'h00:   param_byte = 8'h4f;
      8'h01:   param_byte = 8'h4e;
      8'h02:   param_byte = 8'h46;
      8'h03:   param_byte = 8'h49;
      8'h51:   param_byte = 8'h08;
      8'h54:   param_byte = 8'h80;
      8'h57:   param_byte = 8'h02;
      8'h5a:   param_byte = 8'h20;
      8'h5c:   param_byte = 8'h40;
      8'h61:   param_byte = 8'h04;
      8'h64:   param_byte = 8'h01;
      8'h66:   param_byte = 8'h01;
      8'h67:   param_byte = 8'h14;
      8'h6e:   param_byte = 8'h04;
      default: param_byte = 8'h00;
    endcase
  endfunction : param_byte
endpackage : snrwe_pkg

module snrwe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // Destination clock
  input  wire logic         rst_n, // Asynchronous reset
  input  wire logic [W-1:0] d,     // Foreign level
  output logic      [W-1:0] q      // Synchronised level
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : snrwe_sync

// ---- design/snrwe_core.sv ----
module snrwe_core
  import snrwe_pkg::*;
#(
  parameter int           BUSY_CYCLES = BUSY_CYC,
  parameter logic [7:0]   MAKER_CODE  = 8'h5a,                    // Arbitrary value
  parameter logic [7:0]   PART_CODE   = 8'h3c,                    // Arbitrary value
  parameter logic [127:0] UNIQUE_ID   = 128'h0123456789abcdef_fedcba9876543210 // Arbitrary
) (
  input  wire logic        sys_clk,                          // System clock
  input  wire logic        nrst,                             // Async reset, low
  input  wire logic        sclk,                             // Serial clock from host
  input  wire logic        cs_n,                             // Chip select, low
  input  wire logic [3:0]  sio_in,                           // Serial lines 0..3 in
  output logic      [3:0]  sio_out,                          // Serial lines 0..3 out
  output logic      [3:0]  sio_oe,                           // Serial line drive enables
  input  wire logic [7:0]  configuration_feature_register,   // Quad, ECC, OTP bits
  input  wire logic        array_modify_done,                // Program or erase finished
  output logic             array_req,                        // Array byte request
  output logic      [23:0] array_page_addr,                  // Block and page address
  output logic      [11:0] array_col,                        // Array column
  input  wire logic [7:0]  array_rd_data,                    // Byte, one cycle after col
  output logic             write_enable_latch,               // Latch state
  output logic             operation_in_progress             // Page load busy
);
  typedef enum {LK_CMD, LK_PHASE, LK_DONE} snrwe_link_e;
  typedef enum {FS_IDLE, FS_BUSY} snrwe_fill_e;

  logic [7:0]  cache_mem [0:CACHE_DEPTH-1];
  snrwe_link_e lk_state_reg;
  logic [2:0]  bcnt_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_next;
  logic [5:0]  pc_reg;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic [3:0]  rise_nib_reg;
  logic [7:0]  dtr_byte_reg;
  logic        tog_set_reg;
  logic        tog_clr_reg;
  logic        tog_rst_reg;
  logic        tog_pr_reg;
  logic [23:0] pr_addr_reg;
  logic [9:0]  link_view;
  logic [7:0]  cfg_s;
  logic        latch_s;
  logic        busy_s;
  logic        cmd_end;
  logic [5:0]  start_pc;
  logic [2:0]  lines;
  logic        data_go;
  logic        started_reg;
  logic [11:0] col_reg;
  logic [7:0]  sh_reg;
  logic [2:0]  nbit_reg;
  logic [3:0]  out_reg;
  logic [3:0]  lo_pend_reg;
  logic [3:0]  oe_reg;
  logic [11:0] cur_col;
  logic [11:0] col_lim;
  logic        load_now;
  logic [7:0]  byte_now;
  logic [3:0]  tog_s;
  logic [3:0]  tog_prev_reg;
  logic        set_pls;
  logic        clr_pls;
  logic        rst_pls;
  logic        pr_pls;
  logic        latch_reg;
  snrwe_fill_e fill_state_reg;
  logic [15:0] busy_cnt_reg;
  logic [11:0] fill_col_reg;
  logic        wr_en_reg;
  logic [11:0] wr_col_reg;
  logic [1:0]  kind_reg;
  logic [7:0]  wr_byte;

  function automatic logic [3:0] place(input logic [7:0] b, input logic [2:0] n);
    case (n)
      3'h1:    place = {2'b00, b[7], 1'b0};
      3'h2:    place = {2'b00, b[7:6]};
      default: place = b[7:4];
    endcase
  endfunction : place

  // Link side: command, address and dummy clocks on rising edges
  assign cmd_next = {cmd_reg[6:0], sio_in[0]};
  assign cmd_end  = (lk_state_reg == LK_CMD) && (bcnt_reg == 3'h7);
  assign start_pc = addr_clks(cmd_reg) + dummy_clks(cmd_reg);
  assign lines    = out_lines(cmd_reg);

  always_comb
  begin
    addr_next = addr_reg;
    if (cmd_reg == OP_RD_DTR)
    begin
      if ((pc_reg >= 6'h01) && (pc_reg <= 6'h04))
        addr_next = {addr_reg[23:0], dtr_byte_reg};
    end
    else if (pc_reg < addr_clks(cmd_reg))
    begin
      case (cmd_reg)
        OP_RD_DIO: addr_next = {addr_reg[29:0], sio_in[1:0]};
        OP_RD_QIO: addr_next = {addr_reg[27:0], sio_in};
        default:   addr_next = {addr_reg[30:0], sio_in[0]};
      endcase
    end
  end

  // Chip select high returns the whole link to the opcode phase
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      lk_state_reg <= LK_CMD;
      bcnt_reg     <= 3'h0;
      cmd_reg      <= 8'h00;
      pc_reg       <= 6'h00;
      addr_reg     <= 32'h0;
      rise_nib_reg <= 4'h0;
    end
    else
    begin
      rise_nib_reg <= sio_in;
      case (lk_state_reg)
        LK_CMD:
        begin
          cmd_reg  <= cmd_next;
          bcnt_reg <= bcnt_reg + 3'h1;
          if (bcnt_reg == 3'h7)
          begin
            if (is_quad(cmd_next) && !cfg_s[QUAD_EN_BIT])
              lk_state_reg <= LK_DONE;
            else if ((cmd_next == OP_PAGE_READ) || (out_lines(cmd_next) != 3'h0))
              lk_state_reg <= LK_PHASE;
            else
              lk_state_reg <= LK_DONE;
          end
        end
        LK_PHASE:
        begin
          addr_reg <= addr_next;
          if (pc_reg < start_pc)
            pc_reg <= pc_reg + 6'h01;
        end
        LK_DONE:
          lk_state_reg <= LK_DONE;
        default:
          lk_state_reg <= LK_DONE;
      endcase
    end
  end

  // Events toggle here so that a stopped serial clock loses none of them
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tog_set_reg <= 1'b0;
      tog_clr_reg <= 1'b0;
      tog_rst_reg <= 1'b0;
      tog_pr_reg  <= 1'b0;
      pr_addr_reg <= 24'h0;
    end
    else if (!cs_n)
    begin
      if (cmd_end && (cmd_next == OP_LATCH_SET))
        tog_set_reg <= !tog_set_reg;
      if (cmd_end && (cmd_next == OP_LATCH_CLEAR))
        tog_clr_reg <= !tog_clr_reg;
      if (cmd_end && (cmd_next == OP_RESET))
        tog_rst_reg <= !tog_rst_reg;
      if ((lk_state_reg == LK_PHASE) && (cmd_reg == OP_PAGE_READ) && (pc_reg == 6'h17))
      begin
        tog_pr_reg  <= !tog_pr_reg;
        pr_addr_reg <= addr_next[23:0];
      end
    end
  end

  snrwe_sync #(.W(10)) u_link_sync (
    .clk   (sclk),
    .rst_n (nrst),
    .d     ({configuration_feature_register, latch_reg, operation_in_progress}),
    .q     (link_view)
  );
  assign cfg_s = link_view[9:2];
  assign latch_s = link_view[1];
  assign busy_s  = link_view[0];

  // Link side: output, shifted on falling edges so the host samples on rising
  assign data_go  = (lk_state_reg == LK_PHASE) && (pc_reg >= start_pc) && (lines != 3'h0);
  assign load_now = data_go && (!started_reg || (nbit_reg == 3'h0));
  assign col_lim  = cfg_s[ECC_BIT] ? ECC_END : SPARE_END;

  always_comb
  begin
    if (started_reg)
      cur_col = col_reg;
    else if ((cmd_reg == OP_GET_FEAT) || (cmd_reg == OP_READ_ID))
      cur_col = 12'h000;
    else
      cur_col = addr_reg[11:0];
    case (cmd_reg)
      OP_GET_FEAT:
        if (addr_reg[7:0] == FEAT_CONFIG)
          byte_now = cfg_s;
        else if (addr_reg[7:0] == FEAT_STATUS)
        begin
          byte_now            = 8'h00;
          byte_now[LATCH_BIT] = latch_s;
          byte_now[BUSY_BIT]  = busy_s;
        end
        else
          byte_now = 8'h00;
      OP_READ_ID:
        byte_now = cur_col[0] ? PART_CODE : MAKER_CODE;
      default:
        byte_now = cache_mem[cur_col];
    endcase
  end

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      started_reg  <= 1'b0;
      col_reg      <= 12'h000;
      sh_reg       <= 8'h00;
      nbit_reg     <= 3'h0;
      out_reg      <= 4'h0;
      lo_pend_reg  <= 4'h0;
      oe_reg       <= 4'h0;
      dtr_byte_reg <= 8'h00;
    end
    else
    begin
      dtr_byte_reg <= {rise_nib_reg, sio_in};
      if (load_now)
      begin
        started_reg <= 1'b1;
        if ((cur_col + 12'h001) >= col_lim)
          col_reg <= 12'h000;
        else
          col_reg <= cur_col + 12'h001;
        out_reg     <= place(byte_now, lines);
        sh_reg      <= byte_now << lines;
        lo_pend_reg <= byte_now[3:0];
        case (lines)
          3'h1:    oe_reg <= 4'b0010;
          3'h2:    oe_reg <= 4'b0011;
          default: oe_reg <= 4'b1111;
        endcase
        if (cmd_reg == OP_RD_DTR)
          nbit_reg <= 3'h0;
        else
          nbit_reg <= (3'h7 >> (lines >> 1));
      end
      else if (data_go)
      begin
        out_reg  <= place(sh_reg, lines);
        sh_reg   <= sh_reg << lines;
        nbit_reg <= nbit_reg - 3'h1;
      end
    end
  end

  // In DTR the low nibble rides the high phase of the clock
  assign sio_out = ((cmd_reg == OP_RD_DTR) && sclk) ? lo_pend_reg : out_reg;
  assign sio_oe  = cs_n ? 4'h0 : oe_reg;

  // System side: events from the link
  snrwe_sync #(.W(4)) u_tog_sync (
    .clk   (sys_clk),
    .rst_n (nrst),
    .d     ({tog_pr_reg, tog_rst_reg, tog_clr_reg, tog_set_reg}),
    .q     (tog_s)
  );

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      tog_prev_reg <= 4'h0;
    else
      tog_prev_reg <= tog_s;
  end

  assign set_pls = tog_s[0] ^ tog_prev_reg[0];
  assign clr_pls = tog_s[1] ^ tog_prev_reg[1];
  assign rst_pls = tog_s[2] ^ tog_prev_reg[2];
  assign pr_pls  = tog_s[3] ^ tog_prev_reg[3];

  // A set arriving with any clear wins, so the host's enable is never lost
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      latch_reg <= 1'b0;
    else if (set_pls)
      latch_reg <= 1'b1;
    else if (clr_pls || rst_pls || array_modify_done)
      latch_reg <= 1'b0;
  end
  assign write_enable_latch = latch_reg;

  // Page load into the cache
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fill_state_reg  <= FS_IDLE;
      busy_cnt_reg    <= 16'h0;
      fill_col_reg    <= 12'h000;
      array_page_addr <= 24'h0;
      kind_reg        <= 2'h0;
      wr_en_reg       <= 1'b0;
      wr_col_reg      <= 12'h000;
    end
    else
    begin
      wr_en_reg  <= array_req;
      wr_col_reg <= fill_col_reg;
      case (fill_state_reg)
        FS_IDLE:
          if (pr_pls && !rst_pls)
          begin
            fill_state_reg  <= FS_BUSY;
            busy_cnt_reg    <= 16'(BUSY_CYCLES - 1);
            fill_col_reg    <= 12'h000;
            array_page_addr <= pr_addr_reg;
            if (configuration_feature_register[OTP_BIT] && (pr_addr_reg == IDENT_PAGE))
              kind_reg <= 2'h1;
            else if (configuration_feature_register[OTP_BIT] && (pr_addr_reg == PARAM_PAGE))
              kind_reg <= 2'h2;
            else
              kind_reg <= 2'h0;
          end
        FS_BUSY:
        begin
          if (busy_cnt_reg != 16'h0)
            busy_cnt_reg <= busy_cnt_reg - 16'h1;
          if (array_req)
            fill_col_reg <= fill_col_reg + 12'h001;
          if (rst_pls)
            fill_state_reg <= FS_IDLE;
          else if ((busy_cnt_reg == 16'h0) && !array_req && !wr_en_reg)
            fill_state_reg <= FS_IDLE;
        end
        default:
          fill_state_reg <= FS_IDLE;
      endcase
    end
  end

  assign array_req             = (fill_state_reg == FS_BUSY) && (fill_col_reg < 12'(CACHE_DEPTH));
  assign array_col             = fill_col_reg;
  assign operation_in_progress = (fill_state_reg == FS_BUSY);

  always_comb
  begin
    case (kind_reg)
      2'h1:    wr_byte = wr_col_reg[4] ? ~UNIQUE_ID[8*wr_col_reg[3:0] +: 8]
                                       : UNIQUE_ID[8*wr_col_reg[3:0] +: 8];
      2'h2:    wr_byte = param_byte(wr_col_reg[7:0]);
      default: wr_byte = array_rd_data;
    endcase
  end

  // Cache is written while busy, and once more one cycle after a reset command ends a load; the host reads it after busy clears
  always_ff @(posedge sys_clk)
  begin
    if (wr_en_reg)
      cache_mem[wr_col_reg] <= wr_byte;
  end

  sequence s_read_trig;
    pr_pls && !rst_pls && (fill_state_reg == FS_IDLE);
  endsequence
  sequence s_busy_start;
    operation_in_progress && array_req ##1 operation_in_progress;
  endsequence

  property p_latch_set;
    @(posedge sys_clk) disable iff (!nrst) set_pls |=> write_enable_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");
  property p_latch_clear;
    @(posedge sys_clk) disable iff (!nrst) (clr_pls && !set_pls) |=> !write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");
  property p_rst_clear;
    @(posedge sys_clk) disable iff (!nrst)
      (rst_pls && !set_pls) |=> (!write_enable_latch && !operation_in_progress);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left state");
  property p_done_clear;
    @(posedge sys_clk) disable iff (!nrst)
      (array_modify_done && !set_pls) |=> !write_enable_latch;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("latch kept after op");
  property p_busy_start;
    @(posedge sys_clk) disable iff (!nrst) s_read_trig |=> s_busy_start;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("page load not started");
  property p_busy_len;
    @(posedge sys_clk) disable iff (!nrst)
      ($fell(operation_in_progress) && !$past(rst_pls)) |-> ($past(busy_cnt_reg) == 16'h0);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy ended early");
  property p_quad_gate;
    @(posedge sclk) disable iff (cs_n)
      ($rose(lk_state_reg == LK_PHASE) && is_quad(cmd_reg)) |-> $past(cfg_s[QUAD_EN_BIT]);
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad read without enable");
  property p_col_wrap;
    @(negedge sclk) disable iff (cs_n)
      (load_now && ((cur_col + 12'h001) == col_lim)) |=> (col_reg == 12'h000);
  endproperty
  a_col_wrap: assert property (p_col_wrap) else $error("column did not wrap");
  property p_quad_lines;
    @(negedge sclk) disable iff (cs_n) (started_reg && (lines == 3'h4)) |-> (oe_reg == 4'hf);
  endproperty
  a_quad_lines: assert property (p_quad_lines) else $error("quad not on four lines");
  property p_single_lines;
    @(negedge sclk) disable iff (cs_n) (started_reg && (lines == 3'h1)) |-> (oe_reg == 4'h2);
  endproperty
  a_single_lines: assert property (p_single_lines) else $error("single not on line 1");
endmodule : snrwe_core

// ---- tb/snrwe_host.sv ----
module snrwe_host (
  output logic            sclk,    // Link clock, still between frames
  output logic            cs_n,    // Chip select
  output wire logic [3:0] sio_in,  // Lines seen by device
  input  wire logic [3:0] sio_out, // Device drive values
  input  wire logic [3:0] sio_oe   // Device drive enables
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       d0   = 1'b0;
  logic       flip = 1'b0;
  logic [3:0] oe_acc;
  logic [15:0] qin;
  // A released line changes every edge so a stale bit cannot pass
  always @(sclk) flip = ~flip;
  assign sio_in = {2'b11, sio_oe[1] ? sio_out[1] : flip, d0};
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  task automatic xfer(input logic [31:0] out, input int nout, input int nin,
                      output logic [15:0] din);
    din = '0;
    oe_acc = '0;
    qin = '0;
    cs_n = 1'b0;
    #37;
    for (int i = 0; i < nout; i++)
    begin
      d0 = out[nout-1-i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    for (int i = 0; i < nin; i++)
    begin
      d0 = ~d0;
      #40 sclk = 1'b1;
      din = {din[14:0], sio_in[1]};
      oe_acc |= sio_oe;
      qin = {qin[11:0], sio_out & sio_oe};
      #40 sclk = 1'b0;
    end
    #37 cs_n = 1'b1;
    #163;
  endtask : xfer
endmodule : snrwe_host

// ---- tb/tb_serial_nand_read_write_enable.sv ----
module tb_serial_nand_read_write_enable;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, nrst, done_pulse;
  logic [7:0]  cfg;
  logic [7:0]  rd_data = 8'h00;
  wire logic   sclk, cs_n, array_req, latch, busy;
  wire logic [3:0]  sio_in, sio_out, sio_oe;
  wire logic [23:0] page_addr;
  wire logic [11:0] array_col;
  logic [15:0] din;
  int          n_errors, cmp_count;
  // Arbitrary identifier value
  localparam logic [127:0] ID_VAL = 128'h00112233445566778899aabbccddeeff;
  snrwe_core #(.BUSY_CYCLES(2200), .MAKER_CODE(8'h5a), .PART_CODE(8'h3c),
    .UNIQUE_ID(ID_VAL)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in),
    .sio_out(sio_out), .sio_oe(sio_oe), .configuration_feature_register(cfg),
    .array_modify_done(done_pulse), .array_req(array_req), .array_page_addr(page_addr),
    .array_col(array_col), .array_rd_data(rd_data), .write_enable_latch(latch),
    .operation_in_progress(busy));
  snrwe_host u_host (
    .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe));
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Array stand-in: byte depends on column, one cycle late
  always @(posedge sys_clk) rd_data <= #1 array_col[7:0] ^ 8'ha5;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic cmd(input logic [7:0] op);
    u_host.xfer({24'h0, op}, 8, 0, din);
    repeat (12) @(posedge sys_clk);
    #1;
  endtask : cmd
  task automatic t_latch();
    cmd(8'h06);
    chk("latch set", latch, 1);
    cmd(8'h04);
    chk("latch clr", latch, 0);
    cmd(8'h06);
    done_pulse = 1'b1;
    @(posedge sys_clk) #1 done_pulse = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("latch done", latch, 0);
    cmd(8'h06);
    cmd(8'hff);
    chk("latch rst", latch, 0);
  endtask : t_latch
  task automatic t_id();
    u_host.xfer({16'h0, 8'h9f, 8'h00}, 16, 16, din);
    chk("id", din, 16'h5a3c);
    chk("oe idle", sio_oe, 0);
  endtask : t_id
  task automatic t_page();
    u_host.xfer({8'h13, 24'h000123}, 32, 0, din);
    repeat (6) @(posedge sys_clk);
    chk("busy", busy, 1);
    chk("req", array_req, 1);
    chk("page", page_addr[15:0], 16'h0123);
    u_host.xfer({16'h0, 8'h0f, 8'hc0}, 16, 8, din);
    chk("poll busy", din[0], 1);
    for (int i = 0; i < 20 && din[0] !== 1'b0; i++)
      u_host.xfer({16'h0, 8'h0f, 8'hc0}, 16, 8, din);
    chk("poll end", din[0], 0);
    chk("busy end", busy, 0);
    chk("req idle", array_req, 0);
    @(posedge sys_clk) #1 cfg = 8'h10;
    u_host.xfer({8'h03, 16'h083f, 8'h00}, 32, 16, din);
    chk("ecc tail", din, {8'h3f ^ 8'ha5, 8'h40 ^ 8'ha5});
    chk("oe single", u_host.oe_acc, 4'b0010);
  endtask : t_page
  task automatic t_quad();
    @(posedge sys_clk) #1 cfg = 8'h00;
    u_host.xfer({8'h6b, 16'h0, 8'h00}, 32, 8, din);
    chk("quad off", u_host.oe_acc, 0);
    @(posedge sys_clk) #1 cfg = 8'h01;
    u_host.xfer({8'h6b, 16'h0, 8'h00}, 32, 4, din);
    chk("quad data", u_host.qin, 16'ha5a4);
    chk("oe quad", u_host.oe_acc, 4'hf);
  endtask : t_quad
  // A page read leaves din clear, so the first poll is forced
  task automatic poll();
    din = 16'h0001;
    for (int i = 0; i < 20 && din[0] !== 1'b0; i++)
      u_host.xfer({16'h0, 8'h0f, 8'hc0}, 16, 8, din);
    chk("ready", din[0], 0);
  endtask : poll
  task automatic t_otp();
    logic [15:0] ident;
    @(posedge sys_clk) #1 cfg = 8'h40;
    u_host.xfer({16'h0, 8'h0f, 8'hb0}, 16, 8, din);
    chk("otp on", din[7:0], 8'h40);
    u_host.xfer({8'h13, 24'h000006}, 32, 0, din);
    poll();
    u_host.xfer({8'h03, 16'h0000, 8'h00}, 32, 16, din);
    ident = din;
    chk("ident", ident, {ID_VAL[7:0], ID_VAL[15:8]});
    u_host.xfer({8'h0b, 16'h0010, 8'h00}, 32, 16, din);
    chk("ident pair", ident ^ din, 16'hffff);
    u_host.xfer({8'h03, 16'h0020, 8'h00}, 32, 16, din);
    chk("ident copy", din, ident);
    u_host.xfer({8'h13, 24'h000004}, 32, 0, din);
    poll();
    u_host.xfer({8'h0b, 16'h0100, 8'h00}, 32, 16, din);
    chk("param copy", din, 16'h4f4e);
  endtask : t_otp
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    cfg = 8'h00;
    done_pulse = 1'b0;
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_latch();
    t_id();
    t_page();
    t_quad();
    t_otp();
    summarize();
  end
  initial
  begin
    #400us;
    n_errors++;
    summarize();
  end
endmodule : tb_serial_nand_read_write_enable
